// *** rtl/vsc_pkg.sv ***
package vsc_pkg;
	// ======================================
	// Command framing
	localparam int OP_W     = 5;
	localparam int PARAM_W  = 15;
	localparam int CMD_W    = OP_W + PARAM_W;
	localparam int SECT_W   = 11;
	localparam int BITCNT_W = 5;
	localparam logic [10:0] LAST_SECTOR = 11'h4ff;
	localparam int CELL_W   = 12;
	localparam logic [11:0] CELLS_PER_SECTOR = 12'hfff;
	localparam int DIV_W    = 8;
	localparam int RATE_W   = 2;
	localparam int DIV_LSB  = 2;
	localparam int RATE_LSB = 0;
	localparam logic [7:0] DIV_RESET  = 8'h01;
	localparam logic [1:0] RATE_RESET = 2'h0;
	localparam int BUSY_CYCLES = 4;
	localparam logic [3:0] BUSY_RESET = 4'h0;
	localparam logic [7:0] EXT_TIMEOUT = 8'hff;

	// ======================================
	// Operation codes
	typedef enum logic [4:0] {
		OP_NOP       = 5'h00,
		OP_ID_READ   = 5'h01,
		OP_SET_FWD   = 5'h02,
		OP_FWD       = 5'h03,
		OP_POWER_UP  = 5'h04,
		OP_STOP      = 5'h06,
		OP_HALT      = 5'h07,
		OP_SET_REC   = 5'h08,
		OP_REC       = 5'h09,
		OP_CLEAR     = 5'h0a,
		OP_DIG_WRITE = 5'h0b,
		OP_SET_PLAY  = 5'h0c,
		OP_PLAY      = 5'h0d,
		OP_DIG_READ  = 5'h0f
	} vsc_op_t;

	// ======================================
	// Operating states, Gray along idle-record-play-forward
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_REC   = 3'b001,
		ST_PLAY  = 3'b011,
		ST_FWD   = 3'b010,
		ST_SLEEP = 3'b110
	} vsc_state_t;

	typedef struct packed {
		logic [OP_W-1:0]    op;
		logic [PARAM_W-1:0] param;
	} vsc_cmd_t;

	typedef struct packed {
		vsc_state_t          state;
		logic                extClockPresent;
		logic [SECT_W-1:0]   sector;
		logic                endOfData;
	} vsc_status_t;
endpackage

// *** rtl/vsc_command_port.sv ***
`timescale 1ns/1ps
// Contract
// - Use external sample clock when present, else internal oscillator.
// - External clock divided by host-programmed ratio.
// - Recording advances one cell per sample clock; a tick in the same cycle as an accepted command is dropped.
// - Stopping record marks end of data; playback halts there.
// - Cells after end-of-data marker in that sector are never reused.
// - Memory addressed by sector, 1280 sectors.
// - Sectors 0 to 1279 accepted for audio.
// - Starting a write to a sector discards prior data.
// - Address field 15 bits; low 11 select the sector.
// - Serial bits accepted only while chip select low.
// - Command bits sampled on shift clock rising edge.
// - Busy output low while a command executes.
// - Decode port into strobes; keep readable status word.
// - Squelch control copied to dedicated output.
// - Command is 5-bit code then 15-bit parameter.
// - Power-up command resets and loads divider and rate.
// - Halt command stops and sleeps; only power-up follows.
module vsc_command_port
	import vsc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              chipSelect_n,
	input  wire logic              shiftClock,
	input  wire logic              serial_command_input,
	input  wire logic              external_sample_clock,
	input  wire logic              internalOscTick,
	input  wire logic              squelchActive,
	input  wire logic              endMarkerSeen,
	output logic                   busy_n,
	output logic                   quiet_passage_flag,
	output logic                   sampleTick,
	output logic                   recordStrobe,
	output logic                   playStrobe,
	output logic                   end_of_data_marker,
	output logic                   sectorWipe,
	output logic [SECT_W-1:0]      cellSector,
	output logic [CELL_W-1:0]      cellIndex,
	output logic [RATE_W-1:0]      rateSelect,
	output logic                   idReadStrobe,
	output vsc_status_t            current_state_word
);
	// ======================================
	// Serial shifter
	logic               sclkPrev, csPrev;
	logic [CMD_W-1:0]   shiftReg, next_shiftReg;
	logic [BITCNT_W-1:0] bitCount, next_bitCount;
	logic               cmdValid, next_cmdValid;
	logic               sclkRise;

	assign sclkRise = shiftClock & ~sclkPrev;

	always_comb begin
		next_shiftReg = shiftReg;
		next_bitCount = bitCount;
		next_cmdValid = 1'b0;
		if (chipSelect_n) begin
			next_bitCount = '0;
		end else if (csPrev) begin
			next_bitCount = '0;
			next_shiftReg = '0;
		end else if (sclkRise && bitCount < BITCNT_W'(CMD_W)) begin
			next_shiftReg = {shiftReg[CMD_W-2:0], serial_command_input};
			next_bitCount = bitCount + 1'b1;
			next_cmdValid = (bitCount == BITCNT_W'(CMD_W - 1));
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sclkPrev <= 1'b0;
			csPrev   <= 1'b1;
			shiftReg <= '0;
			bitCount <= '0;
			cmdValid <= 1'b0;
		end else begin
			sclkPrev <= shiftClock;
			csPrev   <= chipSelect_n;
			shiftReg <= next_shiftReg;
			bitCount <= next_bitCount;
			cmdValid <= next_cmdValid;
		end
	end

	vsc_cmd_t cmd;
	assign cmd = vsc_cmd_t'(shiftReg);

	// ======================================
	// Sample clock selection and division
	logic              extPrev, extPresent, next_extPresent;
	logic [7:0]        extIdle, next_extIdle;
	logic [DIV_W-1:0]  divRatio, next_divRatio, divCount, next_divCount;
	logic [RATE_W-1:0] next_rateSelect;
	logic              next_sampleTick, extRise;

	assign extRise = external_sample_clock & ~extPrev;

	always_comb begin
		next_extIdle    = extRise ? '0 : (extIdle == EXT_TIMEOUT ? extIdle : extIdle + 1'b1);
		next_extPresent = (next_extIdle != EXT_TIMEOUT);
		next_divCount   = divCount;
		next_sampleTick = 1'b0;
		if (extPresent) begin
			if (extRise) begin
				if (divCount + 1'b1 >= divRatio) begin
					next_divCount   = '0;
					next_sampleTick = 1'b1;
				end else begin
					next_divCount = divCount + 1'b1;
				end
			end
		end else begin
			next_sampleTick = internalOscTick;
		end
		next_divRatio   = divRatio;
		next_rateSelect = rateSelect;
		if (cmdValid && vsc_op_t'(cmd.op) == OP_POWER_UP) begin
			next_divRatio   = cmd.param[DIV_LSB +: DIV_W];
			next_rateSelect = cmd.param[RATE_LSB +: RATE_W];
			next_divCount   = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			extPrev    <= 1'b0;
			extIdle    <= EXT_TIMEOUT;
			extPresent <= 1'b0;
			divRatio   <= DIV_RESET;
			divCount   <= '0;
			rateSelect <= RATE_RESET;
			sampleTick <= 1'b0;
		end else begin
			extPrev    <= external_sample_clock;
			extIdle    <= next_extIdle;
			extPresent <= next_extPresent;
			divRatio   <= next_divRatio;
			divCount   <= next_divCount;
			rateSelect <= next_rateSelect;
			sampleTick <= next_sampleTick;
		end
	end

	// ======================================
	// Operation control and cell addressing
	vsc_state_t         state, next_state;
	logic [SECT_W-1:0]  next_cellSector;
	logic [CELL_W-1:0]  next_cellIndex;
	logic               next_eod, next_wipe, next_rec, next_play, next_id, eodFlag, next_eodFlag;
	logic [3:0]         busyCount, next_busyCount;
	logic [SECT_W-1:0]  addr;

	assign addr = cmd.param[SECT_W-1:0];

	always_comb begin
		next_state      = state;
		next_cellSector = cellSector;
		next_cellIndex  = cellIndex;
		next_eod        = 1'b0;
		next_wipe       = 1'b0;
		next_id         = 1'b0;
		next_rec        = 1'b0;
		next_play       = 1'b0;
		next_eodFlag    = eodFlag;
		next_busyCount  = (busyCount != BUSY_RESET) ? busyCount - 1'b1 : busyCount;
		if (cmdValid && (state != ST_SLEEP || vsc_op_t'(cmd.op) == OP_POWER_UP)) begin
			next_busyCount = 4'(BUSY_CYCLES);
			case (vsc_op_t'(cmd.op))
				OP_POWER_UP: begin
					next_state      = ST_IDLE;
					next_cellSector = '0;
					next_cellIndex  = '0;
					next_eodFlag    = 1'b0;
				end
				OP_STOP: next_state = ST_IDLE;
				OP_HALT: next_state = ST_SLEEP;
				OP_SET_REC, OP_SET_PLAY, OP_SET_FWD, OP_CLEAR, OP_DIG_WRITE: begin
					if (addr <= LAST_SECTOR) begin
						next_cellSector = addr;
						next_cellIndex  = '0;
						next_eodFlag    = 1'b0;
						next_wipe       = (cmd.op == OP_CLEAR) || (cmd.op == OP_DIG_WRITE);
						next_state = (cmd.op == OP_SET_REC) ? ST_REC :
							(cmd.op == OP_SET_PLAY) ? ST_PLAY :
							(cmd.op == OP_SET_FWD) ? ST_FWD : ST_IDLE;
					end
				end
				OP_REC, OP_PLAY, OP_FWD: begin
					if (cmd.op != OP_REC || !eodFlag) begin
						next_state = (cmd.op == OP_REC) ? ST_REC :
							(cmd.op == OP_PLAY) ? ST_PLAY : ST_FWD;
					end
					if (cmd.op == OP_REC && eodFlag) begin
						next_cellSector = (cellSector == LAST_SECTOR) ? '0 : cellSector + 1'b1;
						next_cellIndex  = '0;
						next_eodFlag    = 1'b0;
						next_state      = ST_REC;
					end
				end
				OP_ID_READ: next_id = 1'b1;
				default: ;
			endcase
			if (state == ST_REC && next_state != ST_REC) begin
				next_eod     = 1'b1;
				next_eodFlag = 1'b1;
			end
		end else if (sampleTick && (state == ST_REC || state == ST_PLAY)) begin
			if (state == ST_PLAY && endMarkerSeen) begin
				next_state = ST_IDLE;
			end else begin
				next_rec  = (state == ST_REC);
				next_play = (state == ST_PLAY);
				if (cellIndex == CELLS_PER_SECTOR) begin
					next_cellIndex  = '0;
					next_cellSector = (cellSector == LAST_SECTOR) ? '0 : cellSector + 1'b1;
				end else begin
					next_cellIndex = cellIndex + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state              <= ST_IDLE;
			cellSector         <= '0;
			cellIndex          <= '0;
			eodFlag            <= 1'b0;
			busyCount          <= BUSY_RESET;
			end_of_data_marker <= 1'b0;
			sectorWipe         <= 1'b0;
			recordStrobe       <= 1'b0;
			playStrobe         <= 1'b0;
			idReadStrobe       <= 1'b0;
			busy_n             <= 1'b1;
			quiet_passage_flag <= 1'b0;
			current_state_word <= '0;
		end else begin
			state              <= next_state;
			cellSector         <= next_cellSector;
			cellIndex          <= next_cellIndex;
			eodFlag            <= next_eodFlag;
			busyCount          <= next_busyCount;
			end_of_data_marker <= next_eod;
			sectorWipe         <= next_wipe;
			recordStrobe       <= next_rec;
			playStrobe         <= next_play;
			idReadStrobe       <= next_id;
			busy_n             <= (next_busyCount == BUSY_RESET);
			quiet_passage_flag <= squelchActive;
			current_state_word <= '{state: next_state, extClockPresent: next_extPresent,
				sector: next_cellSector, endOfData: next_eodFlag};
		end
	end
endmodule

// *** tb/vsc_command_port_props.sv ***
`timescale 1ns/1ps
module vsc_command_port_props
	import vsc_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              chipSelect_n,
	input wire logic              squelchActive,
	input wire logic              busy_n,
	input wire logic              quiet_passage_flag,
	input wire logic              recordStrobe,
	input wire logic              playStrobe,
	input wire logic              end_of_data_marker,
	input wire logic              sectorWipe,
	input wire logic [SECT_W-1:0] cellSector,
	input wire logic [RATE_W-1:0] rateSelect,
	input wire vsc_status_t       current_state_word
);
	// ======================================
	// Port checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence busyWin;
		(!busy_n)[*4] ##1 busy_n;
	endsequence
	quiet_follow_a: assert property (!$past(rst) |-> quiet_passage_flag == $past(squelchActive))
		else $error("quiet flag not following squelch");
	busy_len_a: assert property ($fell(busy_n) |-> busyWin)
		else $error("busy low time wrong");
	select_cmd_a: assert property ($fell(busy_n) |-> $past(chipSelect_n, 2) == 1'b0)
		else $error("command taken while deselected");
	wipe_busy_a: assert property (sectorWipe |-> ##[0:1] !busy_n)
		else $error("wipe outside a command");
	rate_load_a: assert property ($changed(rateSelect) |-> ##[0:1] !busy_n)
		else $error("rate changed outside a command");
	eod_stop_a: assert property (end_of_data_marker |-> ##[0:2] current_state_word.state != ST_REC)
		else $error("marker while still recording");
	sleep_quiet_a: assert property (current_state_word.state == ST_SLEEP |-> !recordStrobe && !playStrobe)
		else $error("cell activity while asleep");
	sector_range_a: assert property ((recordStrobe || playStrobe) |-> cellSector <= LAST_SECTOR)
		else $error("sector out of range");
endmodule
bind vsc_command_port vsc_command_port_props vsc_command_port_props_inst (.*);

// *** tb/vsc_host_model.sv ***
`timescale 1ns/1ps
module vsc_host_model
	import vsc_pkg::*;
(
	input  wire logic clk,
	input  wire logic busy_n,
	output logic      chipSelect_n,
	output logic      shiftClock,
	output logic      serial_command_input
);
	// ======================================
	// Serial command master
	initial begin
		chipSelect_n = 1'b1;
		shiftClock = 1'b0;
		serial_command_input = 1'b0;
	end
	task automatic send(input vsc_cmd_t c, input logic sel);
		int i;
		for (i = 0; i < 400 && busy_n !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		chipSelect_n = !sel;
		for (i = CMD_W - 1; i >= 0; i--) begin
			repeat (2) @(negedge clk);
			shiftClock = 1'b0;
			serial_command_input = c[i];
			repeat (2) @(negedge clk);
			shiftClock = 1'b1;
		end
		repeat (6) @(negedge clk);
		chipSelect_n = 1'b1;
		shiftClock = 1'b0;
		serial_command_input = !serial_command_input;
	endtask
endmodule

// *** tb/vsc_command_port_test.sv ***
`timescale 1ns/1ps
module vsc_command_port_test
	import vsc_pkg::*;
;
	logic              clk, rst, chipSelect_n, shiftClock, serial_command_input, extOn, oscOn;
	logic              external_sample_clock, internalOscTick, squelchActive, endMarkerSeen;
	logic              busy_n, quiet_passage_flag, sampleTick, recordStrobe, playStrobe;
	logic              end_of_data_marker, sectorWipe, idReadStrobe;
	logic [SECT_W-1:0] cellSector;
	logic [CELL_W-1:0] cellIndex;
	logic [RATE_W-1:0] rateSelect, rate;
	vsc_status_t       current_state_word, s;
	logic [16:0]       expQ[$], e;
	logic [31:0]       seed = 32'h0cae;
	int                n_errors, cmp_count, cycles, ph, nTick, nOsc, nRec, nEod, nWipe, nId, nBusy;
	int                nCell, nPlay;

	vsc_command_port vsc_command_port_inst (.*);
	vsc_host_model   vsc_host_model_inst (.*);

	// ======================================
	// Helpers
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input vsc_op_t op, input logic [14:0] p, input logic [16:0] x);
		expQ.push_back(x);
		vsc_host_model_inst.send({op, p}, 1'b1);
	endtask
	task automatic final_report();
		check(16'(expQ.size()), 16'h0);
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ======================================
	// Background stimulus, counters, monitor
	always @(negedge clk) begin
		seed = xs(seed);
		squelchActive = seed[0];
		internalOscTick = oscOn && seed[4:2] == 3'h0;
		if (extOn) begin
			ph++;
			if (ph >= 5) begin
				ph = 0;
				external_sample_clock = !external_sample_clock;
			end
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
		if (!rst) begin
			nCell += recordStrobe;
			nPlay += playStrobe;
			nTick += sampleTick;
			nOsc += internalOscTick;
			nRec += recordStrobe;
			nEod += end_of_data_marker;
			nWipe += sectorWipe;
			nId += idReadStrobe;
			nBusy += !busy_n;
		end
	end
	always begin
		@(posedge busy_n);
		@(negedge clk);
		if (!rst && expQ.size() > 0) begin
			e = expQ.pop_front();
			s = current_state_word;
			check({s.state, e[16] ? cellSector : e[12:2], rateSelect}, e[15:0]);
		end
	end

	// ======================================
	// Main sequence
	initial begin
		{rst, external_sample_clock, internalOscTick, squelchActive, endMarkerSeen} = 5'h10;
		{extOn, oscOn} = 2'h0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		rate = seed[6:5];
		cmd(OP_POWER_UP, {5'h00, 8'h03, rate}, {1'b1, ST_IDLE, 11'h0, rate});
		cmd(OP_SET_REC, {4'h0, LAST_SECTOR}, {1'b1, ST_REC, LAST_SECTOR, rate});
		nCell = 0;
		extOn = 1'b1;
		repeat (40) @(negedge clk);
		{nTick, nRec} = '0;
		repeat (300) @(negedge clk);
		check(16'(nTick >= 9 && nTick <= 11), 16'h1);
		check(16'(current_state_word.extClockPresent), 16'h1);
		extOn = 1'b0;
		repeat (300) @(negedge clk);
		check(16'(current_state_word.extClockPresent), 16'h0);
		{nTick, nOsc, nRec, nEod} = '0;
		oscOn = 1'b1;
		repeat (400) @(negedge clk);
		oscOn = 1'b0;
		repeat (10) @(negedge clk);
		check(16'(nTick), 16'(nOsc));
		check(16'(nRec), 16'(nTick));
		check(16'(cellIndex), 16'(nCell));
		cmd(OP_STOP, 15'h0, {1'b1, ST_IDLE, LAST_SECTOR, rate});
		repeat (10) @(negedge clk);
		check(16'(nEod), 16'h1);
		cmd(OP_SET_PLAY, {4'h0, LAST_SECTOR}, {1'b1, ST_PLAY, LAST_SECTOR, rate});
		repeat (10) @(negedge clk);
		nPlay = 0;
		{oscOn, endMarkerSeen} = 2'h3;
		repeat (200) @(negedge clk);
		check(16'(current_state_word.state), 16'(ST_IDLE));
		check(16'(nPlay), 16'h0);
		{oscOn, endMarkerSeen} = 2'h0;
		$display("sample and marker tests done");
		cmd(OP_SET_REC, 15'h0500, {1'b1, ST_IDLE, LAST_SECTOR, rate});
		cmd(OP_SET_PLAY, 15'h7c05, {1'b1, ST_PLAY, 11'h405, rate});
		cmd(OP_STOP, 15'h0, {1'b1, ST_IDLE, 11'h405, rate});
		{nWipe, nId, nBusy} = '0;
		cmd(OP_CLEAR, 15'h0005, {1'b1, ST_IDLE, 11'h5, rate});
		cmd(OP_ID_READ, 15'h0, {1'b1, ST_IDLE, 11'h5, rate});
		repeat (10) @(negedge clk);
		check(16'(nWipe * 16 + nId), 16'h11);
		nBusy = 0;
		vsc_host_model_inst.send({OP_SET_REC, 15'h0005}, 1'b0);
		repeat (10) @(negedge clk);
		check(16'(nBusy), 16'h0);
		$display("address and strobe tests done");
		cmd(OP_HALT, 15'h0, {1'b1, ST_SLEEP, 11'h5, rate});
		vsc_host_model_inst.send({OP_SET_REC, 15'h0005}, 1'b1);
		repeat (20) @(negedge clk);
		check(16'(current_state_word.state), 16'(ST_SLEEP));
		check(16'(cellSector), 16'h5);
		cmd(OP_POWER_UP, 15'h0006, {1'b1, ST_IDLE, 11'h0, 2'h2});
		repeat (20) @(negedge clk);
		$display("sleep tests done");
		final_report();
	end
endmodule
